/* shared/pbrs_pkg.sv */
package pbrs_pkg;
    // clock
    localparam int unsigned CLK_HZ = 20_000_000;
    // deglitch time in ms
    localparam int unsigned DEGLITCH_TIME_MS = 20;
    localparam int unsigned DEGLITCH_CYCLES = DEGLITCH_TIME_MS * (CLK_HZ / 1000);
    // setup delays of the first option group, in ms
    localparam int unsigned SETUP_LOW_MS = 500;
    localparam int unsigned SETUP_FLOAT_MS = 1000;
    localparam int unsigned SETUP_HIGH_MS = 2000;
    localparam int unsigned SETUP_LOW_CYCLES = SETUP_LOW_MS * (CLK_HZ / 1000);
    localparam int unsigned SETUP_FLOAT_CYCLES = SETUP_FLOAT_MS * (CLK_HZ / 1000);
    localparam int unsigned SETUP_HIGH_CYCLES = SETUP_HIGH_MS * (CLK_HZ / 1000);
    // resistor option: seconds = kohm / 20, so ms = kohm * 50
    localparam int unsigned RES_DIVISOR = 20;
    localparam int unsigned RES_MS_PER_KOHM = 1000 / RES_DIVISOR;
    localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
    // reset pulse time in us (plain default)
    localparam int unsigned RESET_PULSE_TIME_US = 900;
    localparam int unsigned RESET_PULSE_CYCLES = RESET_PULSE_TIME_US * (CLK_HZ / 1_000_000);
    // select pin encodings
    localparam logic [1:0] SEL_LOW = 2'h0;
    localparam logic [1:0] SEL_FLOAT = 2'h1;
    localparam logic [1:0] SEL_HIGH = 2'h2;
    localparam int CNT_W = 32;
endpackage

/* core/pbrs_deglitch.sv */
`timescale 1ns/1ps
module pbrs_deglitch #(
    parameter int unsigned DELAY = 400000
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // raw active-low input, already synchronised
    input wire logic in_n,
    // filtered active-low output
    output logic out_n
);
    logic [31:0] cnt_ff;

    // a falling edge is recognised only after DELAY cycles of steady low;
    // the rising edge passes at once
    always_ff @(posedge clk) begin
        if (reset || in_n) begin
            cnt_ff <= 32'h0;
        end else if (cnt_ff < DELAY) begin
            cnt_ff <= cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || in_n) begin
            out_n <= 1'b1;
        end else if (cnt_ff >= DELAY - 1) begin
            out_n <= 1'b0;
        end
    end
endmodule

/* core/pbrs_top.sv */
`timescale 1ns/1ps
// Behaviour
// - hold reset low during undervoltage, then timeout
// - held button past setup fires one pulse
// - two-button variant needs both held together
// - single-button variant mirrors debounced button
// - falling edges deglitched by 20 ms
// - three-state select chooses the setup delay
// - resistor option: delay seconds equals kohm/20
// - option skips timeout at power-up
// - one pulse per press; release before next
// - first group: 0.5 s, 1 s, 2 s
module pbrs_top #(
    parameter bit TWO_BUTTON = 1'b0,
    parameter bit RESISTOR_MODE = 1'b0,
    parameter bit SKIP_POWERUP_TIMEOUT = 1'b0,
    parameter int unsigned DEGLITCH_CYCLES = pbrs_pkg::DEGLITCH_CYCLES,
    parameter int unsigned SETUP_LOW_CYCLES = pbrs_pkg::SETUP_LOW_CYCLES,
    parameter int unsigned SETUP_FLOAT_CYCLES = pbrs_pkg::SETUP_FLOAT_CYCLES,
    parameter int unsigned SETUP_HIGH_CYCLES = pbrs_pkg::SETUP_HIGH_CYCLES,
    parameter int unsigned CYCLES_PER_MS = pbrs_pkg::CYCLES_PER_MS,
    parameter int unsigned RESET_PULSE_CYCLES = pbrs_pkg::RESET_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // supply monitor, high while undervoltage
    input wire logic undervolt,
    // buttons, active low; button_b_n unused in single-button variant
    input wire logic manual_reset_n,
    input wire logic button_b_n,
    // setup select: three-state code, and resistor value in kohm
    input wire logic [1:0] setup_sel,
    input wire logic [9:0] setup_kohm,
    // outputs
    output logic reset_out_n,
    output logic soft_reset_out_n
);
    typedef enum logic [1:0] {PBRS_POWERUP, PBRS_IDLE, PBRS_PULSE, PBRS_WAIT_REL} pbrs_state_type;

    logic [1:0] sync_a_ff, sync_b_ff, sync_uv_ff;
    logic [1:0] sel_s1_ff, sel_s2_ff;
    logic [9:0] kohm_s1_ff, kohm_s2_ff;
    logic deg_a_n, deg_b_n;
    logic pressed;
    logic [31:0] setup_cnt_ff, pulse_cnt_ff, setup_target;
    pbrs_state_type state_ff;
    logic first_ff;

    // two-stage synchronisers for all pins
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_a_ff <= 2'h3;
            sync_b_ff <= 2'h3;
            sync_uv_ff <= 2'h3;
        end else begin
            sync_a_ff <= {sync_a_ff[0], manual_reset_n};
            sync_b_ff <= {sync_b_ff[0], button_b_n};
            sync_uv_ff <= {sync_uv_ff[0], undervolt};
        end
    end

    // select straps are static, sampled through two stages too
    always_ff @(posedge clk) begin
        sel_s1_ff <= setup_sel;
        sel_s2_ff <= sel_s1_ff;
        kohm_s1_ff <= setup_kohm;
        kohm_s2_ff <= kohm_s1_ff;
    end

    pbrs_deglitch #(.DELAY(DEGLITCH_CYCLES)) u_deg_a (
        .clk(clk),
        .reset(reset),
        .in_n(sync_a_ff[1]),
        .out_n(deg_a_n)
    );

    pbrs_deglitch #(.DELAY(DEGLITCH_CYCLES)) u_deg_b (
        .clk(clk),
        .reset(reset),
        .in_n(sync_b_ff[1]),
        .out_n(deg_b_n)
    );

    // single button uses input a alone; dual needs both low together
    assign pressed = TWO_BUTTON ? (!deg_a_n && !deg_b_n) : !deg_a_n;

    always_comb begin
        if (RESISTOR_MODE) begin
            // ms = kohm * 1000 / 20
            setup_target = 32'(kohm_s2_ff) * 32'(pbrs_pkg::RES_MS_PER_KOHM)
                * 32'(CYCLES_PER_MS);
        end else begin
            unique case (sel_s2_ff)
                pbrs_pkg::SEL_LOW: setup_target = 32'(SETUP_LOW_CYCLES);
                pbrs_pkg::SEL_HIGH: setup_target = 32'(SETUP_HIGH_CYCLES);
                default: setup_target = 32'(SETUP_FLOAT_CYCLES);
            endcase
        end
    end

    // setup counter runs while the press is held, cleared on release
    always_ff @(posedge clk) begin
        if (reset || !pressed) begin
            setup_cnt_ff <= 32'h0;
        end else if (setup_cnt_ff < setup_target) begin
            setup_cnt_ff <= setup_cnt_ff + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            first_ff <= 1'b1;
        end else if (!sync_uv_ff[1]) begin
            first_ff <= 1'b0;
        end
    end

    // undervoltage overrides every state; the timeout restarts on release
    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= PBRS_POWERUP;
            pulse_cnt_ff <= 32'h0;
        end else if (sync_uv_ff[1]) begin
            state_ff <= PBRS_POWERUP;
            pulse_cnt_ff <= 32'h0;
        end else begin
            unique case (state_ff)
                PBRS_POWERUP: begin
                    if (SKIP_POWERUP_TIMEOUT && first_ff) begin
                        state_ff <= PBRS_WAIT_REL;
                    end else begin
                        state_ff <= PBRS_PULSE;
                    end
                    pulse_cnt_ff <= 32'h0;
                end
                PBRS_IDLE: begin
                    if (pressed && setup_cnt_ff >= setup_target) begin
                        state_ff <= PBRS_PULSE;
                        pulse_cnt_ff <= 32'h0;
                    end
                end
                PBRS_PULSE: begin
                    if (pulse_cnt_ff >= 32'(RESET_PULSE_CYCLES) - 32'h1) begin
                        state_ff <= PBRS_WAIT_REL;
                    end else begin
                        pulse_cnt_ff <= pulse_cnt_ff + 32'h1;
                    end
                end
                PBRS_WAIT_REL: begin
                    // a held button must be released before it can fire again
                    if (!pressed) begin
                        state_ff <= PBRS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reset_out_n <= 1'b0;
        end else begin
            reset_out_n <= !(sync_uv_ff[1] || state_ff == PBRS_PULSE
                || state_ff == PBRS_POWERUP);
        end
    end

    // soft reset mirrors the debounced button; held high in dual variant
    always_ff @(posedge clk) begin
        if (reset) begin
            soft_reset_out_n <= 1'b1;
        end else begin
            soft_reset_out_n <= TWO_BUTTON ? 1'b1 : deg_a_n;
        end
    end
endmodule

/* testbench/pbrs_chk.sv */
`timescale 1ns/1ps
module pbrs_chk #(
    parameter int unsigned DEGLITCH_CYCLES = 20,
    parameter int unsigned SETUP_LOW_CYCLES = 50,
    parameter int unsigned SETUP_HIGH_CYCLES = 200,
    parameter int unsigned RESET_PULSE_CYCLES = 30
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // watched pins
    input wire logic undervolt,
    input wire logic manual_reset_n,
    input wire logic reset_out_n,
    input wire logic soft_reset_out_n
);
    localparam int PLO = RESET_PULSE_CYCLES - 10;
    localparam int PHI = RESET_PULSE_CYCLES;
    localparam int DEG = DEGLITCH_CYCLES;
    logic [15:0] low_cnt_ff;
    // button low time, saturating so a long hold never wraps
    always_ff @(posedge clk) begin
        if (reset || manual_reset_n) begin
            low_cnt_ff <= 16'h0000;
        end else if (low_cnt_ff != 16'hffff) begin
            low_cnt_ff <= low_cnt_ff + 16'h0001;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    sequence held_low;
        (!reset_out_n) [*8];
    endsequence
    chk_reset_values: assert property ($fell(reset) |-> !reset_out_n && soft_reset_out_n)
        else $error("outputs wrong after reset");
    chk_uv_holds: assert property (undervolt [*4] |-> !reset_out_n)
        else $error("reset released in undervoltage");
    chk_uv_timeout: assert property ($fell(undervolt) |-> held_low ##[PLO:PHI] $rose(reset_out_n))
        else $error("timeout after undervoltage wrong");
    chk_pulse_width: assert property ($fell(reset_out_n) && !undervolt |-> held_low ##[PLO:PHI] $rose(reset_out_n))
        else $error("pulse length wrong");
    chk_pulse_cause: assert property ($fell(reset_out_n) && !undervolt |->
        low_cnt_ff >= DEG + SETUP_LOW_CYCLES - 4 && low_cnt_ff <= DEG + SETUP_HIGH_CYCLES + 12)
        else $error("pulse without proper hold");
    chk_deglitch_hold: assert property (low_cnt_ff != 16'h0000 && low_cnt_ff < DEG |-> soft_reset_out_n)
        else $error("falling edge passed early");
    chk_soft_follow: assert property (low_cnt_ff == DEG + 8 |-> !soft_reset_out_n)
        else $error("soft reset not following");
    chk_soft_release: assert property (manual_reset_n [*6] |-> soft_reset_out_n)
        else $error("soft reset not released");
endmodule
bind pbrs_top pbrs_chk #(.DEGLITCH_CYCLES(DEGLITCH_CYCLES), .SETUP_LOW_CYCLES(SETUP_LOW_CYCLES),
    .SETUP_HIGH_CYCLES(SETUP_HIGH_CYCLES), .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) u_chk (
    .clk(clk), .reset(reset), .undervolt(undervolt), .manual_reset_n(manual_reset_n),
    .reset_out_n(reset_out_n), .soft_reset_out_n(soft_reset_out_n));

/* testbench/pbrs_up_model.sv */
`timescale 1ns/1ps
module pbrs_up_model (
    // clock
    input wire logic clk,
    // reset line into the processor
    input wire logic reset_in_n,
    // completed low pulses and length of the last one
    output logic [15:0] pulses = 16'h0000,
    output logic [15:0] last_width = 16'h0000
);
    logic [15:0] run_ff = 16'h0000;
    // the processor only listens; an unknown level counts as released
    always @(posedge clk) begin
        if (reset_in_n === 1'b0) begin
            run_ff <= run_ff + 16'h0001;
        end else if (run_ff != 16'h0000) begin
            pulses <= pulses + 16'h0001;
            last_width <= run_ff;
            run_ff <= 16'h0000;
        end
    end
endmodule

/* testbench/test_pushbutton_reset_supervisor.sv */
`timescale 1ns/1ps
module test_pushbutton_reset_supervisor;
    localparam int DEG = 20;
    localparam int PUL = 30;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic undervolt = 1'b0;
    logic manual_reset_n = 1'b1;
    logic button_b_n = 1'b1;
    logic [9:0] setup_kohm = 10'h00a;
    logic [1:0] setup_sel = pbrs_pkg::SEL_FLOAT;
    logic reset_out_n;
    logic soft_reset_out_n;
    logic [15:0] up_pulses;
    logic [15:0] up_width;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    pbrs_top #(.DEGLITCH_CYCLES(DEG), .SETUP_LOW_CYCLES(50), .SETUP_FLOAT_CYCLES(100),
        .SETUP_HIGH_CYCLES(200), .CYCLES_PER_MS(1), .RESET_PULSE_CYCLES(PUL)) dut (
        .clk(clk), .reset(reset), .undervolt(undervolt), .manual_reset_n(manual_reset_n),
        .button_b_n(button_b_n), .setup_sel(setup_sel), .setup_kohm(setup_kohm),
        .reset_out_n(reset_out_n), .soft_reset_out_n(soft_reset_out_n));
    pbrs_up_model up (.clk(clk), .reset_in_n(reset_out_n), .pulses(up_pulses),
        .last_width(up_width));
    task tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task check(input bit ok, input string what);
        tests_run++;
        if (!ok) begin
            miscompares++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task wrap_up;
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // waits for the reset line to reach a level, returns cycles taken
    task wait_out(input logic lvl, output int n);
        n = 0;
        while (reset_out_n !== lvl && n < 1000) begin
            tick(1);
            n++;
        end
    endtask
    task t_brownout;
        int n;
        undervolt = 1'b1;
        tick(6);
        check(reset_out_n === 1'b0, "no reset in undervoltage");
        undervolt = 1'b0;
        wait_out(1'b1, n);
        check(n >= PUL + 1 && n <= PUL + 7, "timeout after undervoltage");
    endtask
    task t_press(input logic [1:0] sel, input int su);
        int n;
        logic [15:0] p0;
        setup_sel = sel;
        tick(4);
        p0 = up_pulses;
        manual_reset_n = 1'b0;
        tick(DEG - 2);
        check(soft_reset_out_n === 1'b1, "edge not deglitched");
        tick(10);
        check(soft_reset_out_n === 1'b0, "soft reset late");
        wait_out(1'b0, n);
        n = n + DEG + 8;
        check(n >= DEG + su + 2 && n <= DEG + su + 8, "setup delay");
        tick(su + 3 * PUL);
        check(up_pulses === p0 + 16'h0001, "pulse count");
        check(up_width >= PUL - 1 && up_width <= PUL + 2, "pulse width");
        manual_reset_n = 1'b1;
        tick(6);
        check(soft_reset_out_n === 1'b1, "soft release");
    endtask
    task t_glitch;
        logic [15:0] p0;
        p0 = up_pulses;
        manual_reset_n = 1'b0;
        tick(DEG - 5);
        manual_reset_n = 1'b1;
        tick(300);
        check(up_pulses === p0 && soft_reset_out_n === 1'b1, "short press acted");
        // single-button build: a long hold on the second button alone must do nothing
        button_b_n = 1'b0;
        tick(DEG + 250);
        button_b_n = 1'b1;
        tick(4);
        check(up_pulses === p0 && reset_out_n === 1'b1, "second button acted");
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 10000) begin
            miscompares++;
            wrap_up;
        end
    end
    initial begin
        int n;
        tick(16);
        reset = 1'b0;
        wait_out(1'b1, n);
        check(n >= PUL - 1 && n <= PUL + 6, "power-up timeout");
        t_brownout;
        t_press(pbrs_pkg::SEL_LOW, 50);
        t_press(pbrs_pkg::SEL_FLOAT, 100);
        t_press(pbrs_pkg::SEL_HIGH, 200);
        t_press(2'h3, 100);
        t_glitch;
        wrap_up;
    end
endmodule
